//--- inc/psp_pkg.sv
// package for the parallel slave port controller
package psp_pkg;
  // register byte addresses (aligned words on the bus)
  localparam logic [7:0] PSP_CTRL_ADDR = 8'h00;
  localparam logic [7:0] PSP_DATA_ADDR = 8'h04;
  localparam logic [7:0] PSP_IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] PSP_IRQ_MASK_ADDR = 8'h0c;
  localparam logic [7:0] PSP_CFG_ADDR = 8'h10;
  // control register fields
  localparam int PSP_IN_FULL_BIT = 7;
  localparam int PSP_OUT_FULL_BIT = 6;
  localparam int PSP_OVF_BIT = 5;
  localparam int PSP_MODE_BIT = 4;
  localparam logic [7:0] PSP_CTRL_RESET = 8'h00;
  // interrupt status fields
  localparam int PSP_EV_WRITE = 0;
  localparam int PSP_EV_READ = 1;
  localparam int PSP_EV_OVF = 2;
  localparam int PSP_EV_W = 3;
  // configuration register fields, then the ahb-lite htrans and hsize encodings
  localparam int PSP_CFG_DIR_LSB = 0;
  localparam int PSP_CFG_DIGITAL_BIT = 3;
  localparam logic [2:0] PSP_DIR_INPUTS = 3'h7;
  localparam logic [3:0] PSP_CFG_RESET = 4'hf;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } psp_strobe_t;

  typedef struct packed {
    logic wr_event;
    logic rd_event;
  } psp_event_t;
endpackage : psp_pkg

//--- hw/psp_sync.sv
// three-stage synchroniser and falling-edge detector for strobe pins
`timescale 1ns/10ps
module psp_sync
  import psp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire psp_strobe_t pins,
  output psp_strobe_t level_q,
  output psp_event_t event_q
);
  psp_strobe_t s1_q;
  psp_strobe_t s2_q;
  psp_strobe_t s3_q;
  logic wr_act_q;
  logic rd_act_q;
  logic wr_act_d;
  logic rd_act_d;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      level_q <= '1;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts once stages two and three agree
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign wr_act_d = ~level_q.cs_n & ~level_q.wr_n;
  assign rd_act_d = ~level_q.cs_n & ~level_q.rd_n;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      event_q <= '0;
    end else begin
      wr_act_q <= wr_act_d;
      rd_act_q <= rd_act_d;
      event_q.wr_event <= wr_act_d & ~wr_act_q;
      event_q.rd_event <= rd_act_d & ~rd_act_q;
    end
  end
endmodule : psp_sync

//--- hw/psp_ctrl.sv
// parallel slave port control and status with ahb-lite registers
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module psp_ctrl
  import psp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mcu_mode,
  input wire logic psp_cs_n,
  input wire logic psp_wr_n,
  input wire logic psp_rd_n,
  input wire logic [7:0] psp_data_in,
  output logic [7:0] psp_data_out,
  output logic psp_data_oe,
  output logic port_d_gpio_sel,
  output logic irq
);
  psp_strobe_t pins;
  psp_strobe_t level;
  psp_event_t ev;
  logic [7:0] in_latch_q;
  logic [7:0] port_d_latch_q;
  logic input_full_flag_q;
  logic output_full_flag_q;
  logic input_overflow_flag_q;
  logic slave_port_mode_select_q;
  logic [2:0] port_e_direction_q;
  logic digital_sel_q;
  logic [PSP_EV_W-1:0] irq_stat_q;
  logic [PSP_EV_W-1:0] irq_mask_q;
  logic mcu_q1;
  logic mcu_q2;
  logic mcu_q3;
  logic mcu_q;
  logic port_on;
  logic wr_ev;
  logic rd_ev;
  logic dp_write_q;
  logic dp_read_q;
  logic [7:0] dp_addr_q;
  logic bus_wr;
  logic cpu_data_rd;
  logic cpu_data_wr;
  logic [7:0] ctrl_rd;
  logic [31:0] rdata_d;

  assign pins = '{cs_n: psp_cs_n, wr_n: psp_wr_n, rd_n: psp_rd_n};

  psp_sync u_sync (
    .clock(clock),
    .reset(reset),
    .pins(pins),
    .level_q(level),
    .event_q(ev)
  );

  // configuration strap level passes its own copy of the pin synchroniser
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mcu_q1 <= 1'b0;
      mcu_q2 <= 1'b0;
      mcu_q3 <= 1'b0;
      mcu_q <= 1'b0;
    end else begin
      mcu_q1 <= mcu_mode;
      mcu_q2 <= mcu_q1;
      mcu_q3 <= mcu_q2;
      if (mcu_q2 == mcu_q3) begin
        mcu_q <= mcu_q3;
      end
    end
  end

  assign port_on = mcu_q & slave_port_mode_select_q
    & (port_e_direction_q == PSP_DIR_INPUTS) & digital_sel_q;
  assign wr_ev = port_on & ev.wr_event;
  assign rd_ev = port_on & ev.rd_event;

  // ahb-lite data phase tracking
  assign bus_wr = hsel & hready & htrans[1] & hwrite & (hsize == HSIZE_WORD);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dp_write_q <= 1'b0;
      dp_read_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_write_q <= bus_wr;
      dp_read_q <= hsel & hready & htrans[1] & ~hwrite;
      if (hsel & hready & htrans[1]) begin
        dp_addr_q <= haddr;
      end
    end
  end

  assign cpu_data_rd = dp_read_q & (dp_addr_q == PSP_DATA_ADDR);
  assign cpu_data_wr = dp_write_q & (dp_addr_q == PSP_DATA_ADDR);

  // byte latches: external writes land in in_latch, cpu writes in port_d_latch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      in_latch_q <= 8'h00;
      port_d_latch_q <= 8'h00;
    end else begin
      if (wr_ev) begin
        in_latch_q <= psp_data_in;
      end
      if (cpu_data_wr) begin
        port_d_latch_q <= hwdata[7:0];
      end
    end
  end

  // status flags; set wins over clear, whether the set comes from hardware or from the cpu
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      input_full_flag_q <= 1'b0;
      output_full_flag_q <= 1'b0;
      input_overflow_flag_q <= 1'b0;
    end else begin
      if (wr_ev) begin
        input_full_flag_q <= 1'b1;
      end else if (cpu_data_rd) begin
        input_full_flag_q <= 1'b0;
      end
      if (cpu_data_wr) begin
        output_full_flag_q <= 1'b1;
      end else if (rd_ev) begin
        output_full_flag_q <= 1'b0;
      end
      if (wr_ev & input_full_flag_q & ~cpu_data_rd) begin
        input_overflow_flag_q <= 1'b1;
      end else if (dp_write_q & (dp_addr_q == PSP_CTRL_ADDR) & ~hwdata[PSP_OVF_BIT]) begin
        input_overflow_flag_q <= 1'b0;
      end
    end
  end

  // software control and configuration
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      slave_port_mode_select_q <= PSP_CTRL_RESET[PSP_MODE_BIT];
      port_e_direction_q <= PSP_CFG_RESET[2:0];
      digital_sel_q <= PSP_CFG_RESET[PSP_CFG_DIGITAL_BIT];
      irq_mask_q <= '0;
    end else if (dp_write_q) begin
      if (dp_addr_q == PSP_CTRL_ADDR) begin
        slave_port_mode_select_q <= hwdata[PSP_MODE_BIT];
      end
      if (dp_addr_q == PSP_CFG_ADDR) begin
        port_e_direction_q <= hwdata[PSP_CFG_DIR_LSB +: 3];
        digital_sel_q <= hwdata[PSP_CFG_DIGITAL_BIT];
      end
      if (dp_addr_q == PSP_IRQ_MASK_ADDR) begin
        irq_mask_q <= hwdata[PSP_EV_W-1:0];
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_stat_q <= '0;
    end else begin
      for (int i = 0; i < PSP_EV_W; i++) begin
        if ((i == PSP_EV_WRITE && wr_ev) || (i == PSP_EV_READ && rd_ev)
            || (i == PSP_EV_OVF && wr_ev && input_full_flag_q && !cpu_data_rd)) begin
          irq_stat_q[i] <= 1'b1;
        end else if (dp_write_q && dp_addr_q == PSP_IRQ_STAT_ADDR && hwdata[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign ctrl_rd = {input_full_flag_q, output_full_flag_q, input_overflow_flag_q,
                    slave_port_mode_select_q, 4'h0};

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hsel & hready & htrans[1] & ~hwrite) begin
      unique case (haddr)
        PSP_CTRL_ADDR: rdata_d = {24'h000000, ctrl_rd};
        PSP_DATA_ADDR: rdata_d = {24'h000000, in_latch_q};
        PSP_IRQ_STAT_ADDR: rdata_d = {29'h0, irq_stat_q};
        PSP_IRQ_MASK_ADDR: rdata_d = {29'h0, irq_mask_q};
        PSP_CFG_ADDR: rdata_d = {28'h0, digital_sel_q, port_e_direction_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // outputs from flip-flops
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      psp_data_out <= 8'h00;
      psp_data_oe <= 1'b0;
      port_d_gpio_sel <= 1'b1;
      irq <= 1'b0;
    end else begin
      hrdata <= rdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      psp_data_out <= port_d_latch_q;
      psp_data_oe <= port_on & ~level.cs_n & ~level.rd_n;
      port_d_gpio_sel <= ~port_on;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule : psp_ctrl

//--- verification/psp_ctrl_checker.sv
// assertion checker for the slave port controller
`timescale 1ns/10ps
module psp_ctrl_checker
  import psp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input logic [31:0] hrdata,
  input logic psp_cs_n,
  input logic psp_rd_n,
  input logic mcu_mode,
  input logic psp_data_oe,
  input logic port_d_gpio_sel,
  input logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic ap = hsel && hready && htrans[1];
  sequence s_ctrl_rd;
    ap && !hwrite && haddr == PSP_CTRL_ADDR;
  endsequence
  sequence s_off8;
    (!mcu_mode)[*8];
  endsequence
  property p_ctrl_rsv;
    s_ctrl_rd |=> hrdata[31:8] == 24'h000000 && hrdata[3:0] == 4'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bits set");
  property p_mcu_gpio;
    s_off8 |-> port_d_gpio_sel;
  endproperty
  a_mcu_gpio: assert property (p_mcu_gpio) else $error("port on without mcu");
  property p_mcu_oe;
    s_off8 |-> !psp_data_oe;
  endproperty
  a_mcu_oe: assert property (p_mcu_oe) else $error("drive without mcu");
  property p_cs_oe;
    psp_cs_n[*8] |-> !psp_data_oe;
  endproperty
  a_cs_oe: assert property (p_cs_oe) else $error("drive without select");
  property p_rd_oe;
    psp_rd_n[*8] |-> !psp_data_oe;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("drive without read");
  property p_oe_act;
    psp_data_oe |-> !port_d_gpio_sel;
  endproperty
  a_oe_act: assert property (p_oe_act) else $error("drive in gpio mode");
  property p_oe_rise;
    $rose(psp_data_oe) |-> !$past(psp_cs_n, 2) && !$past(psp_rd_n, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive without strobes");
  property p_irq_fall;
    $fell(irq) |-> $past(ap, 3) && $past(hwrite, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule : psp_ctrl_checker

//--- verification/psp_ext_master.sv
// external byte-wide master driving the slave port strobes
`timescale 1ns/10ps
module psp_ext_master (
  input wire logic clock,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] dout,
  input wire logic [7:0] din,
  input wire logic din_oe
);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    dout = 8'h00;
  end
  task automatic xfer(input logic w, input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge clock);
    cs_n <= 1'b0;
    wr_n <= !w;
    rd_n <= w;
    dout <= w ? d : ~d;
    repeat (7) @(posedge clock);
    q = din;
    oe = din_oe;
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    dout <= ~d;
    repeat (6) @(posedge clock);
  endtask : xfer
endmodule : psp_ext_master

//--- verification/psp_ctrl_tb.sv
// self-checking bench for the slave port controller
`timescale 1ns/10ps
module psp_ctrl_tb
  import psp_pkg::*;
;
  logic clock = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, mcu_mode = 1'b1;
  logic [7:0] haddr = 8'h00, din, dout;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q;
  logic hready, hresp, cs_n, wr_n, rd_n, oe, gpio, irq, xoe;
  logic [7:0] xq;
  int err_count = 0, check_count = 0;
  always #5 clock = ~clock;
  psp_ctrl uut (.clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD), .hwdata,
    .hready, .hrdata, .hreadyout(hready), .hresp, .mcu_mode, .psp_cs_n(cs_n), .psp_wr_n(wr_n),
    .psp_rd_n(rd_n), .psp_data_in(din), .psp_data_out(dout), .psp_data_oe(oe),
    .port_d_gpio_sel(gpio), .irq);
  psp_ext_master ext (.clock, .cs_n, .wr_n, .rd_n, .dout(din), .din(dout), .din_oe(oe));
  task automatic finish_test();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    // address phase held until hready is seen high at a rising edge
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    // read data taken at the edge that ends the data phase
    wait_rdy();
    q = hrdata;
  endtask : bus
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rdc
  task automatic t_reset();
    rdc("ctrl", PSP_CTRL_ADDR, 32'h0);
    rdc("cfg", PSP_CFG_ADDR, 32'hf);
    rdc("unmapped", 8'h20, 32'h0);
    bus(1'b1, PSP_CTRL_ADDR, 32'hf0);
    rdc("ctrl ro", PSP_CTRL_ADDR, 32'h10);
    chk("gpio", 1'b0, gpio);
    chk("hresp", 32'h0, hresp);
  endtask : t_reset
  task automatic t_write();
    ext.xfer(1'b1, 8'ha5, xq, xoe);
    rdc("ctrl full", PSP_CTRL_ADDR, 32'h90);
    rdc("stat wr", PSP_IRQ_STAT_ADDR, 32'h1);
    rdc("data", PSP_DATA_ADDR, 32'ha5);
    rdc("ctrl read", PSP_CTRL_ADDR, 32'h10);
    ext.xfer(1'b1, 8'h11, xq, xoe);
    ext.xfer(1'b1, 8'h22, xq, xoe);
    rdc("ctrl ovf", PSP_CTRL_ADDR, 32'hb0);
    bus(1'b1, PSP_CTRL_ADDR, 32'h10);
    rdc("ovf clr", PSP_CTRL_ADDR, 32'h90);
    bus(1'b0, PSP_DATA_ADDR, 32'h0);
    bus(1'b1, PSP_IRQ_STAT_ADDR, 32'h7);
    rdc("stat clr", PSP_IRQ_STAT_ADDR, 32'h0);
  endtask : t_write
  task automatic t_read();
    bus(1'b1, PSP_DATA_ADDR, 32'h3c);
    rdc("ctrl obf", PSP_CTRL_ADDR, 32'h50);
    chk("latch", 8'h3c, dout);
    ext.xfer(1'b0, 8'h00, xq, xoe);
    chk("ext data", 8'h3c, xq);
    chk("ext oe", 1'b1, xoe);
    rdc("obf clr", PSP_CTRL_ADDR, 32'h10);
    rdc("stat rd", PSP_IRQ_STAT_ADDR, 32'h2);
    bus(1'b1, PSP_IRQ_STAT_ADDR, 32'h7);
  endtask : t_read
  task automatic t_irq();
    bus(1'b1, PSP_IRQ_MASK_ADDR, 32'h1);
    ext.xfer(1'b1, 8'h5a, xq, xoe);
    chk("irq", 1'b1, irq);
    bus(1'b1, PSP_IRQ_STAT_ADDR, 32'h1);
    repeat (3) @(posedge clock);
    chk("irq clr", 1'b0, irq);
    bus(1'b1, PSP_IRQ_MASK_ADDR, 32'h0);
    bus(1'b0, PSP_DATA_ADDR, 32'h0);
    ext.xfer(1'b1, 8'h5b, xq, xoe);
    chk("irq mask", 1'b0, irq);
    bus(1'b0, PSP_DATA_ADDR, 32'h0);
    bus(1'b1, PSP_IRQ_STAT_ADDR, 32'h7);
  endtask : t_irq
  task automatic t_off();
    mcu_mode <= 1'b0;
    repeat (8) @(posedge clock);
    chk("gpio mcu", 1'b1, gpio);
    ext.xfer(1'b1, 8'h77, xq, xoe);
    rdc("ctrl mcu", PSP_CTRL_ADDR, 32'h10);
    mcu_mode <= 1'b1;
    bus(1'b1, PSP_CFG_ADDR, 32'h8);
    repeat (8) @(posedge clock);
    chk("gpio dir", 1'b1, gpio);
    bus(1'b1, PSP_CFG_ADDR, 32'hf);
    repeat (8) @(posedge clock);
    chk("gpio on", 1'b0, gpio);
  endtask : t_off
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (6) @(posedge clock);
    t_reset();
    t_write();
    t_read();
    t_irq();
    t_off();
    finish_test();
  end
endmodule : psp_ctrl_tb
bind psp_ctrl psp_ctrl_checker chk_i (.clock, .reset, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .psp_cs_n, .psp_rd_n, .mcu_mode, .psp_data_oe, .port_d_gpio_sel, .irq);
